// File: pcr_pkg.sv
// pcr_pkg: shared widths, reset values, states and carrier structs of the packet crc block
package pcr_pkg;

   // ---------------------------------------------------------------
   // datapath shape
   // ---------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int SYMS = 4;
   localparam int SYM_W = DATA_W / SYMS;
   localparam int EMPTY_W = (SYMS > 1) ? $clog2(SYMS) : 1;
   localparam int CRC_W = 32;
   localparam int CHANNELS = 4;
   localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

   // ---------------------------------------------------------------
   // build-time defaults
   // ---------------------------------------------------------------
   localparam logic [CRC_W-1:0] CRC_POLY_DEF = 32'h04c11db7;
   localparam logic [CRC_W-1:0] CRC_INIT_DEF = 32'hffffffff;
   localparam logic [CH_W-1:0] CH_LAST = CH_W'(CHANNELS - 1);

   // ---------------------------------------------------------------
   // fixed latency from end-of-packet word to result-valid, in cycles
   // ---------------------------------------------------------------
   localparam int LAT_AREA = 2;
   localparam int LAT_SPEED = 3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [CRC_W-1:0] CRC_RST = 32'h00000000;
   localparam logic [CH_W-1:0] CH_RST = '0;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [EMPTY_W-1:0] EMPTY_RST = '0;

   // ---------------------------------------------------------------
   // control states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } pcr_st_type;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic [EMPTY_W-1:0] empty;
      logic [CH_W-1:0] chan;
      logic [DATA_W-1:0] data;
   } pcr_word_type;

   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] chan;
      logic [CRC_W-1:0] crc;
      logic bad;
   } pcr_result_type;

   typedef struct packed {
      logic en;
      logic [CH_W-1:0] addr;
      logic [CRC_W-1:0] crc;
   } pcr_ctxwr_type;

   localparam pcr_word_type WORD_RST = '{1'b0, 1'b0, 1'b0, EMPTY_RST, CH_RST, DATA_RST};
   localparam pcr_result_type RES_RST = '{1'b0, CH_RST, CRC_RST, 1'b0};
   localparam pcr_ctxwr_type CTXWR_RST = '{1'b0, CH_RST, CRC_RST};

endpackage : pcr_pkg

// File: pcr_ctx_mem.sv
// pcr_ctx_mem: per-channel crc context memory with registered read data
`timescale 1ns/100ps
module pcr_ctx_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   // clock
   input wire logic clk_sys,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // read returns the old word when the same entry is written in that cycle
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : pcr_ctx_mem

// File: pcr_crc_engine.sv
// pcr_crc_engine: streaming packet crc generator or checker with channel contexts
`timescale 1ns/100ps

// What this block does
// - generator folds each valid input word of message into the running crc
// - checker folds each valid codeword word, message plus checksum, into the crc
// - valid may drop anywhere inside or between packets without harm
// - data, markers and empty are ignored while valid is low
// - generator pulses result-valid with checksum a fixed delay after end word
// - checksum is only meaningful in the result-valid cycle
// - checker pulses result-valid with error flag high on syndrome mismatch
// - error flag is only meaningful in the result-valid cycle
// - a new packet is taken while the previous result is still in flight
// - start may follow end on the very next cycle, both processed right
// - each channel keeps its own crc context in context memory
// - multi-channel works in both speed and area variants
// - result channel output carries the finished packet's channel with result-valid
// - no software access port; only results on dedicated outputs
// - asynchronous active-low reset returns all engine registers to initial values; context memory is not reset
// - empty counts unused low symbols of the end word
// - contexts are initialised after reset, then init-complete rises
// - crc register is preloaded with the starting value before each packet
module pcr_crc_engine import pcr_pkg::*; #(
   parameter logic [CRC_W-1:0] POLY = CRC_POLY_DEF,
   parameter logic [CRC_W-1:0] INIT = CRC_INIT_DEF,
   parameter bit CHECKER = 1'b0,
   parameter bit SPEED_OPT = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // packet stream in
   input wire logic [DATA_W-1:0] data_in,
   input wire logic data_valid,
   input wire logic start_pkt,
   input wire logic end_pkt,
   input wire logic [EMPTY_W-1:0] empty_in,
   input wire logic [CH_W-1:0] chan_in,
   // results out
   output logic crc_valid,
   output logic [CRC_W-1:0] checksum,
   output logic crc_bad,
   output logic [CH_W-1:0] crc_chan,
   output logic init_done
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      pcr_st_type state;
      logic [CH_W-1:0] init_addr;
      pcr_word_type pre;
      pcr_word_type stg;
      pcr_ctxwr_type fwd;
      pcr_result_type res;
   } pcr_engine_type;

   localparam pcr_engine_type ENG_RST = '{ST_INIT, CH_RST, WORD_RST, WORD_RST, CTXWR_RST,
                                          RES_RST};

   pcr_engine_type s_q;
   pcr_engine_type s_d;

   pcr_word_type w_in;
   pcr_word_type front;
   pcr_ctxwr_type ctx_wr;
   logic [CRC_W-1:0] ctx_rd;
   logic [CRC_W-1:0] ctx_cur;
   logic [CRC_W-1:0] crc_base;
   logic [CRC_W-1:0] crc_next;
   logic [EMPTY_W-1:0] eff_empty;

   // ---------------------------------------------------------------
   // crc fold of one word, msb first, skipping empty low symbols
   // ---------------------------------------------------------------
   function automatic logic [CRC_W-1:0] crc_fold(input logic [CRC_W-1:0] crc,
                                                 input logic [DATA_W-1:0] data,
                                                 input logic [EMPTY_W-1:0] empty);
      logic [CRC_W-1:0] c;
      logic fb;
      int skip;
      c = crc;
      fb = 1'b0;
      skip = int'(empty) * SYM_W;
      for (int b = DATA_W - 1; b >= 0; b--) begin
         if (b >= skip) begin
            fb = c[CRC_W-1] ^ data[b];
            c = {c[CRC_W-2:0], 1'b0};
            if (fb) begin
               c = c ^ POLY;
            end
         end
      end
      return c;
   endfunction : crc_fold

   // ---------------------------------------------------------------
   // context memory
   // ---------------------------------------------------------------
   pcr_ctx_mem #(
      .WIDTH(CRC_W),
      .DEPTH(CHANNELS),
      .AW(CH_W)
   ) u_ctx_mem (
      .clk_sys(clk_sys),
      .wr_en(ctx_wr.en),
      .wr_addr(ctx_wr.addr),
      .wr_data(ctx_wr.crc),
      .rd_addr(front.chan),
      .rd_data(ctx_rd)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // input word; fields held when valid is low
      w_in = s_q.pre;
      w_in.valid = 1'b0;
      if (data_valid && s_q.state == ST_RUN) begin
         w_in.valid = 1'b1;
         w_in.sop = start_pkt;
         w_in.eop = end_pkt;
         w_in.empty = empty_in;
         w_in.chan = (CHANNELS > 1) ? chan_in : CH_RST;
         w_in.data = data_in;
      end

      // optional input register stage for speed
      s_d.pre = w_in;
      front = SPEED_OPT ? s_q.pre : w_in;
      s_d.stg = front;

      // context of the word in stage, with forward of last write
      if (s_q.fwd.en && s_q.fwd.addr == s_q.stg.chan) begin
         ctx_cur = s_q.fwd.crc;
      end else begin
         ctx_cur = ctx_rd;
      end
      crc_base = s_q.stg.sop ? INIT : ctx_cur;
      eff_empty = s_q.stg.eop ? s_q.stg.empty : EMPTY_RST;
      crc_next = crc_fold(crc_base, s_q.stg.data, eff_empty);

      // context write: sweep during init, fold result when running
      ctx_wr = CTXWR_RST;
      if (s_q.state == ST_INIT) begin
         ctx_wr.en = 1'b1;
         ctx_wr.addr = s_q.init_addr;
         ctx_wr.crc = INIT;
      end else if (s_q.stg.valid) begin
         ctx_wr.en = 1'b1;
         ctx_wr.addr = s_q.stg.chan;
         ctx_wr.crc = crc_next;
      end
      s_d.fwd = ctx_wr;

      // result, one cycle after the fold; pipeline never stalls
      s_d.res.valid = s_q.stg.valid && s_q.stg.eop;
      if (s_q.stg.valid && s_q.stg.eop) begin
         s_d.res.chan = s_q.stg.chan;
         s_d.res.crc = crc_next;
         s_d.res.bad = CHECKER && (crc_next != CRC_RST);
      end

      // init sequencing
      case (s_q.state)
         ST_INIT: begin
            if (s_q.init_addr == CH_LAST) begin
               s_d.state = ST_RUN;
            end else begin
               s_d.init_addr = s_q.init_addr + CH_W'(1);
            end
         end
         ST_RUN: begin
            s_d.state = ST_RUN;
         end
         default: begin
            s_d.state = ST_INIT;
            s_d.init_addr = CH_RST;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= ENG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs from registers, checksum tied to zero in checker; no other access path
   // ---------------------------------------------------------------
   assign crc_valid = s_q.res.valid;
   assign checksum = CHECKER ? CRC_RST : s_q.res.crc;
   assign crc_bad = s_q.res.bad;
   assign crc_chan = s_q.res.chan;
   assign init_done = (s_q.state == ST_RUN);

endmodule : pcr_crc_engine

// File: pcr_crc_engine_props.sv
// pcr_crc_engine_props: port checks of the packet crc block
`timescale 1ns/100ps
module pcr_crc_engine_props import pcr_pkg::*; #(
   parameter bit CHECKER = 1'b0,
   parameter bit SPEED_OPT = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // stream in
   input wire logic [DATA_W-1:0] data_in,
   input wire logic data_valid,
   input wire logic start_pkt,
   input wire logic end_pkt,
   input wire logic [EMPTY_W-1:0] empty_in,
   input wire logic [CH_W-1:0] chan_in,
   // results out
   input wire logic crc_valid,
   input wire logic [CRC_W-1:0] checksum,
   input wire logic crc_bad,
   input wire logic [CH_W-1:0] crc_chan,
   input wire logic init_done
);
   localparam int LAT = SPEED_OPT ? LAT_SPEED : LAT_AREA;
   wire fin = data_valid && init_done && end_pkt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   lat_fixed_a: assert property (fin |-> ##LAT crc_valid)
      else $error("late result");
   no_stray_a: assert property (!fin |-> ##LAT !crc_valid)
      else $error("stray result");
   res_chan_a: assert property (crc_valid |-> crc_chan == $past(chan_in, LAT))
      else $error("wrong result channel");
   res_hold_a: assert property (!crc_valid |-> $stable(checksum) && $stable(crc_bad))
      else $error("result moved");
   init_keep_a: assert property (init_done |=> init_done)
      else $error("init done dropped");
   init_soon_a: assert property ($rose(rst_b) |-> ##[0:5] init_done)
      else $error("init too slow");
   gen_clean_a: assert property (crc_valid && !CHECKER |-> !crc_bad)
      else $error("bad flag in generator");
   rst_clear_a: assert property (disable iff (1'b0) !rst_b |-> !crc_valid && !init_done)
      else $error("reset not clearing");
endmodule : pcr_crc_engine_props

bind pcr_crc_engine pcr_crc_engine_props #(.CHECKER(CHECKER), .SPEED_OPT(SPEED_OPT)) u_props (
   .clk_sys(clk_sys), .rst_b(rst_b), .data_in(data_in), .data_valid(data_valid),
   .start_pkt(start_pkt), .end_pkt(end_pkt), .empty_in(empty_in), .chan_in(chan_in),
   .crc_valid(crc_valid), .checksum(checksum), .crc_bad(crc_bad), .crc_chan(crc_chan),
   .init_done(init_done));

// File: pcr_src_model.sv
// pcr_src_model: upstream packet source feeding the crc stream
`timescale 1ns/100ps
module pcr_src_model import pcr_pkg::*; (
   // clock and status
   input wire logic clk_sys,
   input wire logic init_done,
   // stream out
   output pcr_word_type w
);
   initial w = WORD_RST;
   task automatic idle();
      @(posedge clk_sys);
      #1 w = '{1'b0, ~w.sop, ~w.eop, ~w.empty, ~w.chan, ~w.data};
   endtask : idle
   task automatic send(input logic s, input logic e, input logic [EMPTY_W-1:0] em,
      input logic [CH_W-1:0] ch, input logic [DATA_W-1:0] d, input int gap);
      while (init_done !== 1'b1) @(posedge clk_sys);
      repeat (gap) idle();
      @(posedge clk_sys);
      #1 w = '{1'b1, s, e, e ? em : EMPTY_RST, ch, d};
   endtask : send
endmodule : pcr_src_model

// File: testbench.sv
// testbench: crc generator and checker against a bit-serial reference
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module testbench import pcr_pkg::*;;
   logic clk_sys, gv, gb, gi, cv, cb, ci;
   logic rst_b = 1'b1;
   logic [CRC_W-1:0] gc, cc;
   logic [CH_W-1:0] gh, chh;
   pcr_word_type w;
   pcr_result_type gq[$], cq[$];
   int fail_count = 0;
   int total_checks = 0;
   pcr_crc_engine u_pcr_crc_engine (.clk_sys(clk_sys), .rst_b(rst_b), .data_in(w.data),
      .data_valid(w.valid), .start_pkt(w.sop), .end_pkt(w.eop), .empty_in(w.empty),
      .chan_in(w.chan), .crc_valid(gv), .checksum(gc), .crc_bad(gb), .crc_chan(gh),
      .init_done(gi));
   pcr_crc_engine #(.CHECKER(1'b1), .SPEED_OPT(1'b0)) u_pcr_crc_engine_area (
      .clk_sys(clk_sys), .rst_b(rst_b), .data_in(w.data), .data_valid(w.valid),
      .start_pkt(w.sop), .end_pkt(w.eop), .empty_in(w.empty), .chan_in(w.chan),
      .crc_valid(cv), .checksum(cc), .crc_bad(cb), .crc_chan(chh), .init_done(ci));
   pcr_src_model u_pcr_src_model (.clk_sys(clk_sys), .init_done(gi), .w(w));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // results taken mid-cycle, where the registered outputs have settled
   always @(negedge clk_sys) begin
      if (gv === 1'b1) gq.push_back(pcr_result_type'{1'b1, gh, gc, gb});
      if (cv === 1'b1) cq.push_back(pcr_result_type'{1'b1, chh, cc, cb});
   end
   // msb-first division over the top nb bits
   function automatic logic [CRC_W-1:0] fold(input logic [CRC_W-1:0] c,
      input logic [DATA_W-1:0] d, input int nb);
      for (int i = DATA_W - 1; i >= DATA_W - nb; i--) begin
         c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ d[i]) ? CRC_POLY_DEF : CRC_RST);
      end
      return c;
   endfunction : fold
   task automatic res(input logic [CH_W-1:0] h, input logic [CRC_W-1:0] c);
      pcr_result_type g;
      pcr_result_type k;
      `CHK("result count", 1'b1, (gq.size() > 0 && cq.size() > 0))
      if (gq.size() > 0 && cq.size() > 0) begin
         g = gq.pop_front();
         k = cq.pop_front();
         `CHK("gen chan", h, g.chan)
         `CHK("checksum", c, g.crc)
         `CHK("gen bad", 1'b0, g.bad)
         `CHK("chk sum", CRC_RST, k.crc)
         `CHK("chk chan", h, k.chan)
         `CHK("crc bad", |c, k.bad)
      end
   endtask : res
   task automatic t_reset();
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK("reset out", 6'h00, {gv, gi, cv, ci, gb, cb})
      `CHK("reset chan", 4'h0, {gh, chh})
      `CHK("reset crc", CRC_RST, gc)
      #1 rst_b = 1'b1;
      repeat (CHANNELS - 1) @(posedge clk_sys);
      #1 `CHK("init early", 1'b0, gi)
      @(posedge clk_sys);
      #1 `CHK("init done", 2'b11, {gi, ci})
      $display("test reset done");
   endtask : t_reset
   task automatic t_gap();
      u_pcr_src_model.send(1'b1, 1'b0, 2'h0, 2'h1, 32'h12345678, 0);
      u_pcr_src_model.send(1'b0, 1'b1, 2'h1, 2'h1, 32'hcafef00d, 3);
      repeat (6) u_pcr_src_model.idle();
      res(2'h1, fold(fold(CRC_INIT_DEF, 32'h12345678, 32), 32'hcafef00d, 24));
      $display("test gap done");
   endtask : t_gap
   task automatic t_b2b();
      logic [CRC_W-1:0] c;
      c = fold(CRC_INIT_DEF, 32'h0badc0de, 32);
      u_pcr_src_model.send(1'b1, 1'b0, 2'h0, 2'h2, 32'h0badc0de, 0);
      u_pcr_src_model.send(1'b0, 1'b1, 2'h0, 2'h2, c, 0);
      u_pcr_src_model.send(1'b1, 1'b0, 2'h0, 2'h2, 32'h0badc0de, 0);
      u_pcr_src_model.send(1'b0, 1'b1, 2'h0, 2'h2, c ^ 32'h00000100, 0);
      repeat (6) u_pcr_src_model.idle();
      res(2'h2, CRC_RST);
      res(2'h2, fold(c, c ^ 32'h00000100, 32));
      $display("test back to back done");
   endtask : t_b2b
   task automatic t_mix();
      u_pcr_src_model.send(1'b1, 1'b0, 2'h0, 2'h0, 32'h01020304, 0);
      u_pcr_src_model.send(1'b1, 1'b1, 2'h2, 2'h3, 32'h55aa55aa, 0);
      u_pcr_src_model.send(1'b0, 1'b1, 2'h3, 2'h0, 32'hdeadbeef, 1);
      repeat (6) u_pcr_src_model.idle();
      res(2'h3, fold(CRC_INIT_DEF, 32'h55aa55aa, 16));
      res(2'h0, fold(fold(CRC_INIT_DEF, 32'h01020304, 32), 32'hdeadbeef, 8));
      $display("test channels done");
   endtask : t_mix
   task automatic t_rerun();
      u_pcr_src_model.send(1'b1, 1'b0, 2'h0, 2'h1, 32'h13579bdf, 0);
      u_pcr_src_model.idle();
      t_reset();
      u_pcr_src_model.send(1'b0, 1'b1, 2'h0, 2'h1, 32'h2468ace0, 0);
      repeat (6) u_pcr_src_model.idle();
      res(2'h1, fold(CRC_INIT_DEF, 32'h2468ace0, 32));
      `CHK("spare results", 0, gq.size() + cq.size())
      $display("test reset in run done");
   endtask : t_rerun
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      #1;
      t_reset();
      t_gap();
      t_b2b();
      t_mix();
      t_rerun();
      end_sim();
   end
   initial begin
      #300000;
      fail_count++;
      end_sim();
   end
endmodule : testbench
